// [core/fbsc_top.sv]
/*
 contents: flash boot and security control: boot bank choice, isp switching,
 security enforcement on code reads and port 0 encoding.
 assumptions: SYS_CLK is the machine cycle; register port strobes one cycle.
*/
`timescale 1ns/1ns
module fbsc_top
   import fbsc_pkg::*;
#(
   parameter logic [7:0] ENC_KEY = 8'hA5, // encoding key, arbitrary value
   parameter int SEC_W = 4
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire fbsc_req_t REG_REQ,
   output logic [7:0] REG_RDATA,
   input wire logic REBOOT_STRAP_PIN,
   input wire logic IDLE_ENTER,
   input wire logic IDLE_WAKE,
   input wire fbsc_tread_t TREAD_REQ,
   input wire logic [7:0] PORT0_DATA_IN,
   input wire logic [SEC_W-1:0] SEC_PROG_LOW,
   input wire logic SEC_PROG_STB,
   input wire logic CHIP_ERASE,
   output logic BANK_SEL,
   output logic CORE_RESET,
   output logic TREAD_GRANT,
   output logic ACCESS_BLOCK,
   output logic [7:0] PORT0_DATA_OUT,
   output logic [7:0] UPDATE_CTRL
);
   import fbsc_pkg::*;

   // state of the block, apart from the security bits held in u_sec
   typedef struct packed {
      fbsc_bank_t bank_q; // selected boot flash
      fbsc_state_t state_q; // isp sequencer
      logic [7:0] boot_ctrl_q; // boot_program_control
      logic [7:0] upd_ctrl_q; // flash_update_control
      logic [7:0] rdata_q; // read answer
      logic [3:0] rst_cnt_q; // software reset countdown
      logic core_rst_q; // core reset output
      logic grant_q; // code read granted
      logic block_q; // access refused
      logic [7:0] p0_q; // encoded port 0
      logic strap_done_q; // strap captured since reset
   } fbsc_st_t;

   fbsc_st_t st_q, st_d;
   logic [SEC_W-1:0] sec_bits; // active low security bits
   logic [SEC_W-1:0] sec_prog; // bits to be programmed this cycle
   logic wr_boot, wr_upd, wr_sec; // register write decodes
   logic lock_on, inhib_on, enc_on, reboot_on;

   // address compare shared by all write decodes
   function automatic logic hit(input fbsc_req_t r, input logic [3:0] off);
      hit = r.wr && (r.addr == off);
   endfunction

   assign wr_boot = hit(REG_REQ, FBSC_OFF_BOOT_CTRL);
   assign wr_upd = hit(REG_REQ, FBSC_OFF_UPD_CTRL);
   assign wr_sec = hit(REG_REQ, FBSC_OFF_SEC_PROG) | SEC_PROG_STB;
   // register port write uses low nibble; pin port takes precedence
   assign sec_prog = SEC_PROG_STB ? SEC_PROG_LOW :
                     (wr_sec ? REG_REQ.wdata[SEC_W-1:0] : '0);

   // decoded security controls, active low in storage
   assign lock_on = ~sec_bits[FBSC_SEC_LOCK];
   assign inhib_on = ~sec_bits[FBSC_SEC_INHIB];
   assign enc_on = ~sec_bits[FBSC_SEC_ENC];
   assign reboot_on = ~sec_bits[FBSC_SEC_REBOOT];

   // one-time bit store
   fbsc_sec_bits #(
      .WIDTH(SEC_W)
   ) u_sec (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .prog_low(sec_prog),
      .chip_erase(CHIP_ERASE),
      .bits(sec_bits)
   );

   // next state: one pass over every field of the block state
   always_comb begin
      st_d = st_q;
      // read data stands for one cycle only, zero otherwise
      st_d.rdata_q = FBSC_ZERO8;
      // strap takes effect once, at the first cycle after reset release
      if (!st_q.strap_done_q) begin
         st_d.strap_done_q = 1'b1;
         // strap wiring kept safe by the board, so this read is trusted
         if (reboot_on && !REBOOT_STRAP_PIN) begin
            // option bit programmed and strap low: loader boot
            st_d.bank_q = FBSC_BANK_LDR;
         end else begin
            // every other combination keeps the default bank
            st_d.bank_q = FBSC_BANK_APP;
         end
      end
      // register writes; settings refused while locked
      if (wr_boot && !lock_on) begin
         st_d.boot_ctrl_q = REG_REQ.wdata;
      end
      if (wr_upd && !lock_on) begin
         st_d.upd_ctrl_q = REG_REQ.wdata;
      end
      // register reads, answered next cycle
      if (REG_REQ.rd) begin
         unique case (REG_REQ.addr)
            FBSC_OFF_BOOT_CTRL: begin
               // locked settings read back as zero
               st_d.rdata_q = lock_on ? FBSC_ZERO8 : st_q.boot_ctrl_q;
            end
            FBSC_OFF_UPD_CTRL: begin
               // same refusal for the update control setting
               st_d.rdata_q = lock_on ? FBSC_ZERO8 : st_q.upd_ctrl_q;
            end
            FBSC_OFF_STATUS: begin
               // status stays readable so software can see the lock
               st_d.rdata_q[FBSC_ST_BANK] = st_q.bank_q;
               st_d.rdata_q[FBSC_ST_PEND] = (st_q.state_q == FBSC_ARMED);
               st_d.rdata_q[FBSC_ST_SEC +: SEC_W] = sec_bits;
            end
            default: st_d.rdata_q = FBSC_ZERO8; // unmapped reads zero
         endcase
      end
      // isp sequencer
      st_d.core_rst_q = 1'b0;
      unique case (st_q.state_q)
         FBSC_RUN: begin
            // software reset only means something while running the loader
            if (wr_boot && !lock_on && REG_REQ.wdata == FBSC_CMD_SW_RESET
                && st_q.bank_q == FBSC_BANK_LDR) begin
               st_d.bank_q = FBSC_BANK_APP;
               st_d.rst_cnt_q = FBSC_RST_PULSE;
               st_d.state_q = FBSC_RESETTING;
            end else if (IDLE_ENTER && (st_q.boot_ctrl_q == FBSC_CMD_LDR_ISP
                         || st_q.boot_ctrl_q == FBSC_CMD_APP_ISP)) begin
               // idle entry with a pending command arms the switch
               st_d.state_q = FBSC_ARMED;
            end
         end
         FBSC_ARMED: begin
            // wake-up decides whether the bank changes
            if (IDLE_WAKE) begin
               if (st_q.boot_ctrl_q == FBSC_CMD_LDR_ISP) begin
                  st_d.bank_q = FBSC_BANK_LDR;
                  st_d.rst_cnt_q = FBSC_RST_PULSE;
                  st_d.state_q = FBSC_RESETTING;
               end else begin
                  // loader code lives in the running bank: no switch
                  st_d.state_q = FBSC_RUN;
               end
            end
         end
         FBSC_RESETTING: begin
            // hold core in reset; bank already switched and kept
            st_d.core_rst_q = 1'b1;
            st_d.rst_cnt_q = st_q.rst_cnt_q - 4'h1;
            if (st_q.rst_cnt_q == 4'h1) begin
               // last reset cycle: back to running, command consumed
               st_d.state_q = FBSC_RUN;
               st_d.boot_ctrl_q = FBSC_ZERO8;
            end
         end
         default: begin
            // unused code: recover to running rather than hang
            st_d.state_q = FBSC_RUN;
         end
      endcase
      // code_table_read gating; answer registered, one cycle after the request
      st_d.grant_q = 1'b0;
      if (TREAD_REQ.valid) begin
         if (lock_on && TREAD_REQ.target_int) begin
            // lock hides internal code from every table read
            st_d.grant_q = 1'b0;
         end else if (!TREAD_REQ.from_ext) begin
            // reads issued from internal code are restricted only by the lock
            st_d.grant_q = 1'b1;
         end else begin
            // external code may not peek inside while inhibit is active
            st_d.grant_q = !(inhib_on && TREAD_REQ.target_int);
         end
      end
      // block flag lags the lock bit by one cycle, like every output
      st_d.block_q = lock_on;
      // port 0 encoding is a simple keyed xor; weak, but cheap and reversible
      st_d.p0_q = enc_on ? (PORT0_DATA_IN ^ ENC_KEY) : PORT0_DATA_IN;
   end

   // state register; async reset puts the block back to default boot
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= '{bank_q: FBSC_BANK_APP,
                  state_q: FBSC_RUN,
                  boot_ctrl_q: 8'h00,
                  upd_ctrl_q: 8'h00,
                  rdata_q: 8'h00,
                  rst_cnt_q: 4'h0,
                  core_rst_q: 1'b0,
                  grant_q: 1'b0,
                  block_q: 1'b0,
                  p0_q: 8'h00,
                  strap_done_q: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign REG_RDATA = st_q.rdata_q;
   assign BANK_SEL = st_q.bank_q;
   assign CORE_RESET = st_q.core_rst_q;
   assign TREAD_GRANT = st_q.grant_q;
   assign ACCESS_BLOCK = st_q.block_q;
   assign PORT0_DATA_OUT = st_q.p0_q;
   assign UPDATE_CTRL = st_q.upd_ctrl_q;

   // checks: boot bank choice at reset release

   // no strap condition: application flash
   default_boot_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !st_q.strap_done_q && !(reboot_on && !REBOOT_STRAP_PIN) |=> BANK_SEL == FBSC_BANK_APP)
      else $error("default boot not application");

   // option bit and low strap: loader flash
   strap_boot_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !st_q.strap_done_q && reboot_on && !REBOOT_STRAP_PIN |=> BANK_SEL == FBSC_BANK_LDR)
      else $error("strap reboot missed");

   // checks: isp sequencing

   // wake after 03H: loader bank, then four reset cycles
   ldr_switch_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_q.state_q == FBSC_ARMED && IDLE_WAKE && st_q.boot_ctrl_q == FBSC_CMD_LDR_ISP
      |=> BANK_SEL == FBSC_BANK_LDR ##1 CORE_RESET [*4]) else $error("loader switch wrong");

   // 83H from the loader: application bank, then reset
   app_return_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_q.state_q == FBSC_RUN && wr_boot && !lock_on && REG_REQ.wdata == FBSC_CMD_SW_RESET
      && BANK_SEL == FBSC_BANK_LDR |=> BANK_SEL == FBSC_BANK_APP ##1 CORE_RESET)
      else $error("return to application wrong");

   // wake after 01H: neither bank change nor reset
   app_stay_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_q.state_q == FBSC_ARMED && IDLE_WAKE && st_q.boot_ctrl_q == FBSC_CMD_APP_ISP
      |=> $stable(BANK_SEL) && !CORE_RESET) else $error("bank moved on 01H");

   // checks: security enforcement

   // locked setting reads as zero
   lock_read_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      lock_on && REG_REQ.rd && REG_REQ.addr == FBSC_OFF_UPD_CTRL |=> REG_RDATA == 8'h00)
      else $error("locked register readable");

   // locked setting ignores writes
   upd_locked_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      lock_on && wr_upd |=> $stable(UPDATE_CTRL))
      else $error("locked register written");

   // block flag set the cycle after the lock bit is set
   block_follow_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      lock_on |=> ACCESS_BLOCK)
      else $error("block flag missing");

   // external table read into internal code refused under inhibit
   tread_inhib_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      TREAD_REQ.valid && TREAD_REQ.from_ext && TREAD_REQ.target_int && inhib_on |=> !TREAD_GRANT)
      else $error("inhibited table read granted");

   // internal table read always granted while unlocked
   tread_int_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      TREAD_REQ.valid && !TREAD_REQ.from_ext && !lock_on |=> TREAD_GRANT)
      else $error("internal table read refused");

   // encoded port 0 image
   encode_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      enc_on |=> PORT0_DATA_OUT == ($past(PORT0_DATA_IN) ^ ENC_KEY))
      else $error("port 0 not encoded");

   // plain port 0 image while encryption is off
   plain_port_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !enc_on |=> PORT0_DATA_OUT == $past(PORT0_DATA_IN))
      else $error("port 0 altered");

   // bank only moves for a reset or an isp step
   strap_once_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_q.strap_done_q && st_q.state_q == FBSC_RUN && !wr_boot |=> $stable(BANK_SEL))
      else $error("bank changed without cause");

   // main scenarios reached
   isp_ldr_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_q.state_q == FBSC_ARMED ##1 st_q.state_q == FBSC_RESETTING);
   sw_reset_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      BANK_SEL == FBSC_BANK_LDR ##1 BANK_SEL == FBSC_BANK_APP);
   tread_block_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      TREAD_REQ.valid && TREAD_REQ.from_ext && inhib_on);
   strap_ldr_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      !st_q.strap_done_q && reboot_on && !REBOOT_STRAP_PIN);
endmodule

// [shared/fbsc_pkg.sv]
/*
 contents: constants, state encodings and carrier structs for the flash boot
 and security control block.
 assumptions: included by every design file of the block; no timescale here.
*/
package fbsc_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] FBSC_OFF_BOOT_CTRL = 4'h0; // boot_program_control
   localparam logic [3:0] FBSC_OFF_UPD_CTRL = 4'h1; // flash_update_control
   localparam logic [3:0] FBSC_OFF_STATUS = 4'h2; // boot and security status
   localparam logic [3:0] FBSC_OFF_SEC_PROG = 4'h3; // security bit programming
   // command values written to boot_program_control
   localparam logic [7:0] FBSC_CMD_LDR_ISP = 8'h03;
   localparam logic [7:0] FBSC_CMD_SW_RESET = 8'h83;
   localparam logic [7:0] FBSC_CMD_APP_ISP = 8'h01;
   // security field positions, each bit active low
   localparam int FBSC_SEC_LOCK = 0;
   localparam int FBSC_SEC_INHIB = 1;
   localparam int FBSC_SEC_ENC = 2;
   localparam int FBSC_SEC_REBOOT = 3;
   localparam logic [3:0] FBSC_SEC_ERASED = 4'hF; // all bits inactive
   // status register field positions
   localparam int FBSC_ST_BANK = 0;
   localparam int FBSC_ST_PEND = 1;
   localparam int FBSC_ST_SEC = 4;
   localparam logic [7:0] FBSC_ZERO8 = 8'h00;
   // software reset pulse length in machine cycles
   localparam logic [3:0] FBSC_RST_PULSE = 4'h4;

   // which flash code is fetched from
   typedef enum logic [0:0] {
      FBSC_BANK_APP = 1'b0,
      FBSC_BANK_LDR = 1'b1
   } fbsc_bank_t;

   // isp sequencer
   typedef enum logic [1:0] {
      FBSC_RUN = 2'b00,
      FBSC_ARMED = 2'b01,
      FBSC_RESETTING = 2'b10
   } fbsc_state_t;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } fbsc_req_t;

   // code_table_read request from the core
   typedef struct packed {
      logic valid;
      logic from_ext; // instruction fetched from external memory
      logic target_int; // address points into internal flash
   } fbsc_tread_t;
endpackage

// [core/fbsc_sec_bits.sv]
/*
 contents: one-time security bit store; bits only move toward active (low), except on chip erase.
 assumptions: chip erase comes from the programming controller as a pulse;
 the cells keep their value through reset, so erase must run once at power-up.
*/
`timescale 1ns/1ns
module fbsc_sec_bits
   import fbsc_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] prog_low, // bits to activate
   input wire logic chip_erase,
   output logic [WIDTH-1:0] bits
);
   import fbsc_pkg::*;
   typedef struct packed {logic [WIDTH-1:0] bits_q;} fbsc_sec_st_t;
   fbsc_sec_st_t st_q, st_d;

   // programming may only clear bits; erase restores all
   always_comb begin
      st_d = st_q;
      if (chip_erase) begin
         st_d.bits_q = {WIDTH{1'b1}};
      end else begin
         st_d.bits_q = st_q.bits_q & ~prog_low;
      end
   end

   // models the nonvolatile cells; no reset, a reset must not undo a bit
   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign bits = st_q.bits_q;

   sticky_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      !chip_erase |=> (bits & ~$past(bits)) == '0) else $error("security bit released");
endmodule

// [verif/fbsc_pin_model.sv]
/*
 holds: model of the board around the block: external reset and boot strap.
 assumes: the bench asks for reset and for a low strap; clock is SYS_CLK.
*/
`timescale 1ns/1ns
module fbsc_pin_model (
   input wire logic clk, // machine cycle
   input wire logic rst_cmd, // bench asks for an external reset
   input wire logic strap_low, // bench asks for the strap pulled low
   output logic rst_n, // reset pin, active low
   output logic strap_pin // reboot_strap_pin level
);
   // reset asserts at once, releases on a clock edge like a supervisor chip
   always_ff @(posedge clk or posedge rst_cmd) begin
      if (rst_cmd) begin
         rst_n <= 1'b0;
      end else begin
         rst_n <= 1'b1;
      end
   end
   // strap rests high through its pull resistor, so no mode is entered by chance
   assign strap_pin = ~strap_low;
endmodule

// [verif/testbench.sv]
/*
 holds: self-checking bench for the flash boot and security control block.
 assumes: fbsc_pkg compiled first; the pin model drives reset and strap.
*/
`timescale 1ns/1ns
module testbench;
   import fbsc_pkg::*;
   logic sys_clk, rst_n, strap, rst_cmd, strap_low, idle_enter, idle_wake;
   logic sec_stb, erase, bank_sel, core_reset, grant, block;
   logic [7:0] rdata, p0_in, p0_out, upd_ctrl, upd;
   logic [3:0] sec_low, sec_exp; // sec_exp is the expected store, active low
   logic [31:0] seed = 32'h00001411; // fixed seed keeps runs repeatable
   fbsc_req_t req;
   fbsc_tread_t tread;
   int failures = 0;
   int samples_checked = 0;

   fbsc_pin_model fbsc_pin_model_inst (.clk(sys_clk), .rst_cmd(rst_cmd), .strap_low(strap_low),
      .rst_n(rst_n), .strap_pin(strap));
   fbsc_top fbsc_top_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
      .REBOOT_STRAP_PIN(strap), .IDLE_ENTER(idle_enter), .IDLE_WAKE(idle_wake), .TREAD_REQ(tread),
      .PORT0_DATA_IN(p0_in), .SEC_PROG_LOW(sec_low), .SEC_PROG_STB(sec_stb), .CHIP_ERASE(erase),
      .BANK_SEL(bank_sel), .CORE_RESET(core_reset), .TREAD_GRANT(grant), .ACCESS_BLOCK(block),
      .PORT0_DATA_OUT(p0_out), .UPDATE_CTRL(upd_ctrl));

   // free-running machine cycle, 50 ns
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // expected grant: lock hides internal code, inhibit hides it from external code
   function automatic logic exp_grant(input logic fext, input logic tint);
      return !((~sec_exp[0] & tint) | (fext & tint & ~sec_exp[1]));
   endfunction
   // expected port 0 image
   function automatic logic [7:0] exp_p0(input logic [7:0] d);
      return sec_exp[2] ? d : d ^ 8'hA5;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // external reset held five cycles, then settle
   task automatic rst_pulse();
      @(posedge sys_clk) rst_cmd <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rst_cmd <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk) req.wr <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk) req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // command, optional idle and wake, then count reset cycles
   task automatic isp(input logic [7:0] cmd, input bit idle, input logic bank, input int rsts);
      int n;
      n = 0;
      reg_wr(FBSC_OFF_BOOT_CTRL, cmd);
      if (idle) begin
         @(posedge sys_clk) idle_enter <= 1'b1;
         @(posedge sys_clk) begin
            idle_enter <= 1'b0;
            idle_wake <= 1'b1;
         end
         @(posedge sys_clk) idle_wake <= 1'b0;
      end
      repeat (10) begin
         #1 n += (core_reset === 1'b1);
         @(posedge sys_clk);
      end
      #1 chk({7'h00, bank_sel}, {7'h00, bank});
      chk(8'(n), 8'(rsts));
   endtask
   task automatic sec_prog(input logic [3:0] b);
      @(posedge sys_clk) begin
         sec_low <= b;
         sec_stb <= 1'b1;
      end
      @(posedge sys_clk) sec_stb <= 1'b0;
      sec_exp = sec_exp & ~b;
      @(posedge sys_clk);
      #1;
   endtask
   // random table reads with port 0 traffic alongside
   task automatic tread_run();
      logic [31:0] r;
      repeat (16) begin
         r = rnd();
         @(posedge sys_clk) begin
            tread <= '{1'b1, r[0], r[1]};
            p0_in <= r[15:8];
         end
         @(posedge sys_clk) tread.valid <= 1'b0;
         #1 chk({7'h00, grant}, {7'h00, exp_grant(r[0], r[1])});
         chk(p0_out, exp_p0(r[15:8]));
      end
   endtask

   // hang guard, far beyond the few hundred cycles of the sequence
   initial begin
      repeat (5000) @(posedge sys_clk);
      failures++;
      end_sim();
   end
   initial begin
      req = '0;
      tread = '0;
      // erase at power-up gives the security cells a known state
      {rst_cmd, strap_low, idle_enter, idle_wake, sec_stb, erase} = 6'b100001;
      {p0_in, sec_low} = 12'h000;
      sec_exp = FBSC_SEC_ERASED;
      @(posedge sys_clk) erase <= 1'b0;
      rst_pulse();
      chk({7'h00, bank_sel}, 8'h00);
      reg_rd(FBSC_OFF_STATUS, 8'hF0);
      reg_rd(4'hF, 8'h00);
      // strap moving after reset must not move the bank
      @(posedge sys_clk) strap_low <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 chk({7'h00, bank_sel}, 8'h00);
      // strap low but option bit still erased: application boot
      rst_pulse();
      chk({7'h00, bank_sel}, 8'h00);
      // option bit programmed, strap still low: loader boot, kept over reset
      sec_prog(4'h8);
      rst_pulse();
      chk({7'h00, bank_sel}, 8'h01);
      @(posedge sys_clk) strap_low <= 1'b0;
      isp(FBSC_CMD_SW_RESET, 1'b0, 1'b0, 4);
      isp(FBSC_CMD_SW_RESET, 1'b0, 1'b0, 0);
      isp(FBSC_CMD_APP_ISP, 1'b1, 1'b0, 0);
      isp(FBSC_CMD_LDR_ISP, 1'b1, 1'b1, 4);
      upd = 8'(rnd());
      reg_wr(FBSC_OFF_UPD_CTRL, upd);
      @(posedge sys_clk);
      #1 chk(upd_ctrl, upd);
      reg_rd(FBSC_OFF_UPD_CTRL, upd);
      isp(FBSC_CMD_SW_RESET, 1'b0, 1'b0, 4);
      tread_run();
      sec_prog(4'h2);
      tread_run();
      reg_wr(FBSC_OFF_SEC_PROG, 8'h04);
      sec_exp = sec_exp & 4'hB;
      tread_run();
      reg_rd(FBSC_OFF_STATUS, {sec_exp, 4'h0});
      // lock: settings and boot control go dark
      sec_prog(4'h1);
      chk({7'h00, block}, 8'h01);
      reg_wr(FBSC_OFF_UPD_CTRL, ~upd);
      @(posedge sys_clk);
      #1 chk(upd_ctrl, upd);
      reg_rd(FBSC_OFF_UPD_CTRL, 8'h00);
      isp(FBSC_CMD_LDR_ISP, 1'b1, 1'b0, 0);
      tread_run();
      // only a whole-chip erase brings the bits back
      @(posedge sys_clk) erase <= 1'b1;
      @(posedge sys_clk) erase <= 1'b0;
      sec_exp = FBSC_SEC_ERASED;
      repeat (2) @(posedge sys_clk);
      #1 chk({7'h00, block}, 8'h00);
      reg_rd(FBSC_OFF_STATUS, 8'hF0);
      end_sim();
   end
endmodule
